// File: src/fpnc_top.sv
`timescale 1ns/1ps
`include "fpnc_defs.svh"
module fpnc_top
    import fpnc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode inputs
    input  wire logic        dn_mode,
    input  wire logic        ftz_mode,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [2:0]  instr_class,
    input  wire logic [1:0]  instr_sign_op,
    input  wire logic [31:0] instr_word,
    input  wire logic [31:0] op_a,
    input  wire logic [31:0] op_b,
    // Datapath result
    input  wire logic [31:0] dp_result,
    input  wire logic        dp_tiny_before,
    input  wire logic        dp_tiny_after,
    input  wire logic        dp_risk_tiny,
    input  wire logic        dp_inexact,
    input  wire logic        dp_overflow,
    // Completion
    output logic             result_valid,
    output logic [31:0]      result_data,
    output logic             bounce,
    output logic             inv_trap,
    output logic             exc_taken,
    output logic             exc_pending,
    // Host flag transfer
    output logic             host_flags_valid,
    output logic [3:0]       host_flags
);
    fpnc_class_e cls;
    fpnc_state_e state_q;
    logic        a_nan, a_snan, a_qnan, a_sub, a_zero;
    logic        b_nan, b_snan, b_qnan, b_sub, b_zero;
    logic        nan_any, snan_any, sub_any, two_op;
    logic        exec, take;
    logic        set_inv, set_ioc, set_ufc, set_ixc, do_trap, do_bounce;
    logic        do_wr, do_cc, cap_inter, do_flagx;
    logic [31:0] res;
    logic [3:0]  cc_new, cc_ord;
    logic [31:0] status_q, exc_q, inter_q, instr_q;
    logic        wr_en, rd_en, addr_ok;
    logic        invalid_op_trap_enable;

    assign cls    = fpnc_class_e'(instr_class);
    assign invalid_op_trap_enable    = status_q[`FPNC_ST_IOE];
    assign two_op = (cls != FPNC_NONAR) && (cls != FPNC_XFER);

    fpnc_opclass u_cls_a (
        .op      (op_a),
        .is_nan  (a_nan),
        .is_snan (a_snan),
        .is_qnan (a_qnan),
        .is_sub  (a_sub),
        .is_zero (a_zero)
    );

    fpnc_opclass u_cls_b (
        .op      (op_b),
        .is_nan  (b_nan),
        .is_snan (b_snan),
        .is_qnan (b_qnan),
        .is_sub  (b_sub),
        .is_zero (b_zero)
    );

    assign nan_any  = a_nan | (two_op & b_nan);
    assign snan_any = a_snan | (two_op & b_snan);
    assign sub_any  = a_sub | (two_op & b_sub);

    // Issue while pending only triggers exception processing
    assign take = instr_valid & (state_q == FPNC_EXC);
    // Host is never stalled; issue in the run state executes at once
    assign exec = instr_valid & (state_q == FPNC_RUN);

    // Ordered compare, subnormals count as zero under flush
    always_comb begin
        logic za, zb, lt_mag;
        za     = a_zero | (ftz_mode & a_sub);
        zb     = b_zero | (ftz_mode & b_sub);
        lt_mag = (op_a[30:0] < op_b[30:0]);
        if (za && zb) begin
            cc_ord = `FPNC_CC_EQ;
        end else if (op_a == op_b) begin
            cc_ord = `FPNC_CC_EQ;
        end else if (op_a[`FPNC_SIGN] != op_b[`FPNC_SIGN]) begin
            cc_ord = op_a[`FPNC_SIGN] ? `FPNC_CC_LT : `FPNC_CC_GT;
        end else if (op_a[`FPNC_SIGN]) begin
            cc_ord = lt_mag ? `FPNC_CC_GT : `FPNC_CC_LT;
        end else begin
            cc_ord = lt_mag ? `FPNC_CC_LT : `FPNC_CC_GT;
        end
    end

    // Per-instruction decision
    always_comb begin
        set_inv   = 1'b0;
        set_ioc   = 1'b0;
        set_ufc   = 1'b0;
        set_ixc   = 1'b0;
        do_trap   = 1'b0;
        do_bounce = 1'b0;
        do_wr     = 1'b0;
        do_cc     = 1'b0;
        cap_inter = 1'b0;
        do_flagx  = 1'b0;
        res       = dp_result;
        cc_new    = cc_ord;
        unique case (cls)
            FPNC_ARITH: begin
                if (nan_any && !dn_mode) begin
                    set_inv   = 1'b1;
                    do_bounce = 1'b1;
                end else if (snan_any) begin
                    set_ioc = 1'b1;
                    do_trap = invalid_op_trap_enable;
                    do_wr   = !invalid_op_trap_enable;
                    res     = `FPNC_DNAN_S;
                end else if (nan_any) begin
                    do_wr = 1'b1;
                    res   = `FPNC_DNAN_S;
                end else if (ftz_mode && dp_tiny_before) begin
                    do_wr   = 1'b1;
                    res     = `FPNC_POS_ZERO;
                    set_ufc = 1'b1;
                end else if (!ftz_mode && dp_risk_tiny) begin
                    do_bounce = 1'b1;
                    cap_inter = 1'b1;
                    // Tininess judged after rounding only
                    set_ufc   = dp_tiny_after;
                    set_ixc   = dp_inexact;
                end else begin
                    do_wr     = 1'b1;
                    set_ixc   = dp_inexact;
                    cap_inter = dp_overflow;
                end
            end
            FPNC_NONAR: begin
                do_wr = 1'b1;
                res   = op_a;
                unique case (fpnc_sign_e'(instr_sign_op))
                    FPNC_ABS: res[`FPNC_SIGN] = 1'b0;
                    FPNC_NEG: res[`FPNC_SIGN] = ~op_a[`FPNC_SIGN];
                    default:  res = op_a;
                endcase
            end
            FPNC_CMP, FPNC_CMPE: begin
                if (nan_any && !dn_mode) begin
                    set_inv   = 1'b1;
                    do_bounce = 1'b1;
                end else if (nan_any) begin
                    // Signaling compare raises invalid on any NaN
                    set_ioc = snan_any || (cls == FPNC_CMPE);
                    do_trap = set_ioc && invalid_op_trap_enable;
                    do_cc   = !do_trap;
                    cc_new  = `FPNC_CC_UN;
                end else if (!ftz_mode && sub_any) begin
                    do_bounce = 1'b1;
                end else begin
                    do_cc = 1'b1;
                end
            end
            FPNC_XFER: begin
                do_wr = 1'b1;
                res   = op_a;
            end
            FPNC_FLAGX: begin
                do_flagx = 1'b1;
            end
            default: begin
                do_wr = 1'b0;
            end
        endcase
    end

    // Exceptional state machine; pending flag kept as its own flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= FPNC_RUN;
            exc_pending <= 1'b0;
        end else if (exec && (do_trap || do_bounce)) begin
            state_q     <= FPNC_EXC;
            exc_pending <= 1'b1;
        end else if (wr_en && (paddr == `FPNC_OFF_EXC) && !pwdata[`FPNC_EX_PEND]) begin
            state_q     <= FPNC_RUN;
            exc_pending <= 1'b0;
        end
    end

    // Completion outputs; destination untouched on exception
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_valid <= 1'b0;
            result_data  <= 32'h0000_0000;
        end else begin
            result_valid <= exec & do_wr;
            if (exec && do_wr) begin
                result_data <= res;
            end
        end
    end

    // Bounce, trap and exception-entry pulses
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bounce    <= 1'b0;
            inv_trap  <= 1'b0;
            exc_taken <= 1'b0;
        end else begin
            bounce    <= exec & do_bounce;
            inv_trap  <= exec & do_trap;
            exc_taken <= take;
        end
    end

    // Flag transfer to host program status
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_flags_valid <= 1'b0;
        end else begin
            host_flags_valid <= exec & do_flagx;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_flags <= 4'h0;
        end else if (exec && do_flagx) begin
            host_flags <= status_q[`FPNC_ST_N:`FPNC_ST_V];
        end
    end

    // Status and control: software write, hardware set wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `FPNC_ST_RST;
        end else begin
            logic [31:0] nxt;
            nxt = status_q;
            if (wr_en && (paddr == `FPNC_OFF_STATUS)) begin
                nxt = pwdata;
            end
            if (exec) begin
                nxt[`FPNC_ST_IOC] = nxt[`FPNC_ST_IOC] | set_ioc;
                nxt[`FPNC_ST_UFC] = nxt[`FPNC_ST_UFC] | set_ufc;
                nxt[`FPNC_ST_IXC] = nxt[`FPNC_ST_IXC] | set_ixc;
                if (do_cc) begin
                    nxt[`FPNC_ST_N:`FPNC_ST_V] = cc_new;
                end
            end
            status_q <= nxt;
        end
    end

    // Exception register and captured context
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_q <= `FPNC_EX_RST;
        end else begin
            logic [31:0] nxt;
            nxt = exc_q;
            if (wr_en && (paddr == `FPNC_OFF_EXC)) begin
                nxt = pwdata;
            end
            nxt[`FPNC_EX_PEND] = 1'b0;
            if (exec) begin
                nxt[`FPNC_EX_INV]    = nxt[`FPNC_EX_INV] | set_inv;
                nxt[`FPNC_EX_TRAP]   = nxt[`FPNC_EX_TRAP] | do_trap;
                nxt[`FPNC_EX_BOUNCE] = nxt[`FPNC_EX_BOUNCE] | do_bounce;
            end
            exc_q <= nxt;
        end
    end

    // Intermediate result for the trap path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inter_q <= 32'h0000_0000;
        end else if (exec && cap_inter) begin
            inter_q <= dp_result;
        end
    end

    // Faulting instruction word
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_q <= 32'h0000_0000;
        end else if (exec && (do_trap || do_bounce)) begin
            instr_q <= instr_word;
        end
    end

    // APB slave, one wait state per access
    assign addr_ok = (paddr == `FPNC_OFF_STATUS) || (paddr == `FPNC_OFF_EXC) ||
                     (paddr == `FPNC_OFF_INTER) || (paddr == `FPNC_OFF_INSTR);
    assign wr_en   = psel & penable & pwrite & pready & addr_ok;
    assign rd_en   = psel & penable & ~pwrite & ~pready;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // Error answer for unmapped offsets, alongside ready
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & penable & ~pready & ~addr_ok;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                `FPNC_OFF_STATUS: prdata <= status_q;
                `FPNC_OFF_EXC:    prdata <= exc_q | {exc_pending, 31'h0000_0000};
                `FPNC_OFF_INTER:  prdata <= inter_q;
                `FPNC_OFF_INSTR:  prdata <= instr_q;
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// File: src/fpnc_defs.svh
`ifndef FPNC_DEFS_SVH
`define FPNC_DEFS_SVH
// Notes on behaviour
// - Default-NaN off, arithmetic with any NaN sets input exception flag and bounces.
// - Default-NaN on, arithmetic with quiet NaN returns default NaN, no bounce.
// - Default-NaN on, signaling NaN sets invalid flag; default NaN if trap disabled.
// - Invalid flag with trap enable set bounces to invalid trap, no result.
// - Abs, negate, copy pass NaN with sign change only, no exception.
// - Loads, stores and transfers move NaNs unchanged, no exception or bounce.
// - Default-NaN off, any compare with a NaN sets input flag and bounces.
// - Default-NaN on, plain compare unordered; signaling NaN also raises invalid.
// - Default-NaN on, signaling compare gives unordered and always raises invalid.
// - Compare results go to status flags; transfer instruction copies them to host.
// - Hardware compare gives distinct codes for less, equal and greater.
// - Flush-to-zero off, compare with subnormal operand bounces.
// - Underflow uses after-rounding tininess; loss only from subnormalization.
// - Flush-to-zero on, tiny-before-rounding result becomes +0 and sets underflow.
// - Flush-to-zero off, operation at risk of tiny result bounces.
// - Bounced result not tiny: underflow clear, inexact set when inexact.
// - Bounced result tiny: subnormal or zero delivered, underflow flag set.
// - Exceptions imprecise; next coprocessor instruction starts exception processing.
// - Host runs on meanwhile; further instructions may retire before processing.
// - Exceptional instruction keeps sources and never writes its destination.
// - Overflow or underflow intermediate result is made available to trap path.
// - Default NaN: sign zero, exponent all ones, top fraction bit only set.
// - NaN with top fraction bit zero is signaling, one is quiet.

// Register byte offsets
`define FPNC_OFF_STATUS   8'h00
`define FPNC_OFF_EXC      8'h04
`define FPNC_OFF_INTER    8'h08
`define FPNC_OFF_INSTR    8'h0C
// Status and control fields
`define FPNC_ST_IOC       0
`define FPNC_ST_UFC       3
`define FPNC_ST_IXC       4
`define FPNC_ST_IOE       8
`define FPNC_ST_V         28
`define FPNC_ST_N         31
`define FPNC_ST_RST       32'h0000_0000
// Exception register fields
`define FPNC_EX_TRAP      0
`define FPNC_EX_BOUNCE    1
`define FPNC_EX_INV       7
`define FPNC_EX_PEND      31
`define FPNC_EX_RST       32'h0000_0000
// Single-precision layout and double-precision default NaN
`define FPNC_SIGN         31
`define FPNC_QBIT         22
`define FPNC_EXP_ONES     8'hFF
`define FPNC_DNAN_S       32'h7FC0_0000
`define FPNC_DNAN_D       64'h7FF8_0000_0000_0000
`define FPNC_POS_ZERO     32'h0000_0000
// Condition codes N Z C V
`define FPNC_CC_LT        4'h8
`define FPNC_CC_EQ        4'h6
`define FPNC_CC_GT        4'h2
`define FPNC_CC_UN        4'h3
`endif

// File: src/fpnc_pkg.sv
package fpnc_pkg;
    typedef enum logic [2:0] {
        FPNC_ARITH  = 3'h0,
        FPNC_NONAR  = 3'h1,
        FPNC_CMP    = 3'h2,
        FPNC_CMPE   = 3'h3,
        FPNC_XFER   = 3'h4,
        FPNC_FLAGX  = 3'h5
    } fpnc_class_e;
    typedef enum logic [1:0] {
        FPNC_COPY   = 2'h0,
        FPNC_ABS    = 2'h1,
        FPNC_NEG    = 2'h2
    } fpnc_sign_e;
    typedef enum logic {
        FPNC_RUN    = 1'b0,
        FPNC_EXC    = 1'b1
    } fpnc_state_e;
endpackage

// File: src/fpnc_opclass.sv
`timescale 1ns/1ps
`include "fpnc_defs.svh"
module fpnc_opclass
    import fpnc_pkg::*;
(
    // Operand
    input  wire logic [31:0] op,
    // Class
    output logic             is_nan,
    output logic             is_snan,
    output logic             is_qnan,
    output logic             is_sub,
    output logic             is_zero
);
    logic exp_ones;
    logic exp_zero;
    logic frac_nz;

    assign exp_ones = (op[30:23] == `FPNC_EXP_ONES);
    assign exp_zero = (op[30:23] == 8'h00);
    assign frac_nz  = |op[22:0];
    assign is_nan   = exp_ones & frac_nz;
    assign is_snan  = is_nan & ~op[`FPNC_QBIT];
    assign is_qnan  = is_nan & op[`FPNC_QBIT];
    assign is_sub   = exp_zero & frac_nz;
    assign is_zero  = exp_zero & ~frac_nz;
endmodule

// File: tb/fpnc_top_assertions.sv
`timescale 1ns/1ps
`include "fpnc_defs.svh"
module fpnc_chk
    import fpnc_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Modes and issue
    input wire logic        dn_mode,
    input wire logic        ftz_mode,
    input wire logic        instr_valid,
    input wire logic [2:0]  instr_class,
    input wire logic [1:0]  instr_sign_op,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic        dp_tiny_before,
    input wire logic        dp_risk_tiny,
    // Completion
    input wire logic        result_valid,
    input wire logic [31:0] result_data,
    input wire logic        bounce,
    input wire logic        inv_trap,
    input wire logic        exc_taken,
    input wire logic        exc_pending
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic nan(input logic [31:0] x);
        return x[30:23] == `FPNC_EXP_ONES && x[22:0] != 23'h0;
    endfunction
    function automatic logic qn(input logic [31:0] x);
        return nan(x) && x[`FPNC_QBIT];
    endfunction
    function automatic logic sn(input logic [31:0] x);
        return nan(x) && !x[`FPNC_QBIT];
    endfunction
    function automatic logic sub(input logic [31:0] x);
        return x[30:23] == 8'h00 && x[22:0] != 23'h0;
    endfunction

    // Accepted issue of one class
    sequence go(logic [2:0] c);
        instr_valid && !exc_pending && instr_class == c;
    endsequence
    sequence clean_write;
        result_valid && !bounce && !inv_trap;
    endsequence

    nan_bounce_a:
    assert property (go(3'h0) ##0 (!dn_mode && (nan(op_a) || nan(op_b)))
        |=> bounce && !result_valid) else $error("nan not bounced");
    qnan_default_a:
    assert property (go(3'h0) ##0 (dn_mode && (qn(op_a) || qn(op_b)) && !sn(op_a)
        && !sn(op_b)) |=> clean_write ##0 result_data == `FPNC_DNAN_S)
        else $error("no default nan");
    trap_no_write_a:
    assert property (inv_trap |-> !result_valid) else $error("trap wrote result");
    negate_pass_a:
    assert property (go(3'h1) ##0 instr_sign_op == 2'h2
        |=> clean_write ##0 (result_data ^ $past(op_a)) == 32'h8000_0000)
        else $error("negate wrong");
    xfer_pass_a:
    assert property (go(3'h4) |=> clean_write ##0 result_data == $past(op_a))
        else $error("transfer altered");
    sub_cmp_a:
    assert property (go(3'h2) ##0 (!ftz_mode && (sub(op_a) || sub(op_b))) |=> bounce)
        else $error("subnormal compare kept");
    ftz_flush_a:
    assert property (go(3'h0) ##0 (ftz_mode && dp_tiny_before && !nan(op_a) && !nan(op_b))
        |=> clean_write ##0 result_data == `FPNC_POS_ZERO) else $error("not flushed");
    risk_bounce_a:
    assert property (go(3'h0) ##0 (!ftz_mode && dp_risk_tiny && !nan(op_a) && !nan(op_b))
        |=> bounce && !result_valid) else $error("risky op kept");
    exc_entry_a:
    assert property (instr_valid && exc_pending |=> exc_taken && !result_valid)
        else $error("pending not taken");
    bounce_no_write_a:
    assert property (bounce |-> !result_valid) else $error("bounce wrote result");
endmodule

bind fpnc_top fpnc_chk chk_u (
    .ref_clk, .rst_n, .dn_mode, .ftz_mode, .instr_valid, .instr_class, .instr_sign_op,
    .op_a, .op_b, .dp_tiny_before, .dp_risk_tiny, .result_valid, .result_data,
    .bounce, .inv_trap, .exc_taken, .exc_pending
);

// File: tb/fpnc_host_model.sv
`timescale 1ns/1ps
module fpnc_host_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Instruction issue
    output logic             instr_valid,
    output logic [2:0]       instr_class,
    output logic [1:0]       instr_sign_op,
    output logic [31:0]      op_a,
    output logic [31:0]      op_b,
    // Datapath side
    output logic [31:0]      dp_result,
    output logic             dp_tiny_before,
    output logic             dp_tiny_after,
    output logic             dp_risk_tiny,
    output logic             dp_inexact,
    // Flag transfer
    input  wire logic        host_flags_valid,
    input  wire logic [3:0]  host_flags,
    output logic [3:0]       host_status
);
    initial begin
        {instr_valid, instr_class, instr_sign_op} = 6'h00;
        {op_a, op_b, dp_result} = 96'h0;
        {dp_inexact, dp_risk_tiny, dp_tiny_after, dp_tiny_before} = 4'h0;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_status <= 4'h0;
        end else if (host_flags_valid) begin
            host_status <= host_flags;
        end
    end

    // Operands scrambled once released
    task automatic issue(input logic [2:0] c, input logic [1:0] s, input logic [31:0] a,
                         input logic [31:0] b, input logic [3:0] f);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_class <= c;
        instr_sign_op <= s;
        op_a <= a;
        op_b <= b;
        dp_result <= a + b;
        {dp_inexact, dp_risk_tiny, dp_tiny_after, dp_tiny_before} <= f;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        op_a <= ~a;
        op_b <= ~b;
        dp_result <= ~(a + b);
        {dp_inexact, dp_risk_tiny, dp_tiny_after, dp_tiny_before} <= ~f;
    endtask
endmodule

// File: tb/fpnc_top_tb_top.sv
`timescale 1ns/1ps
`include "fpnc_defs.svh"
module fpnc_top_tb_top
    import fpnc_pkg::*;
;
    localparam logic [31:0] QN = 32'h7FC0_0001, SN = 32'h7F80_0001, NSN = 32'hFF80_0001;
    localparam logic [31:0] ONE = 32'h3F80_0000, TWO = 32'h4000_0000, SUB = 32'h0000_0001;
    localparam logic [3:0]  RV = 4'h8, BO = 4'h4, TR = 4'h2, EX = 4'h1, NO = 4'h0;
    localparam logic [7:0]  ST = `FPNC_OFF_STATUS, XR = `FPNC_OFF_EXC;
    logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, dn_mode, ftz_mode;
    logic        instr_valid, dp_tiny_before, dp_tiny_after, dp_risk_tiny, dp_inexact;
    logic        result_valid, bounce, inv_trap, exc_taken, exc_pending, host_flags_valid;
    logic        err, dp_overflow;
    logic [1:0]  instr_sign_op;
    logic [2:0]  instr_class;
    logic [3:0]  host_flags, host_status;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, op_a, op_b, dp_result, result_data, rd, instr_word;
    logic [31:0] cmp_a [3] = '{ONE, ONE, TWO};
    logic [31:0] cmp_b [3] = '{TWO, ONE, ONE};
    logic [31:0] sgn_r [3] = '{NSN, SN, SN};
    logic [3:0]  ccode [3] = '{`FPNC_CC_LT, `FPNC_CC_EQ, `FPNC_CC_GT};
    int          miscompares, tests_run;

    // Instruction word tagged by its operands
    assign instr_word = op_a ^ op_b;

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    fpnc_top dut_u (
        .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dn_mode, .ftz_mode, .instr_valid, .instr_class, .instr_sign_op,
        .instr_word, .op_a, .op_b, .dp_result, .dp_tiny_before,
        .dp_tiny_after, .dp_risk_tiny, .dp_inexact, .dp_overflow, .result_valid,
        .result_data, .bounce, .inv_trap, .exc_taken, .exc_pending, .host_flags_valid,
        .host_flags
    );
    fpnc_host_model host_u (
        .ref_clk, .rst_n, .instr_valid, .instr_class, .instr_sign_op, .op_a, .op_b,
        .dp_result, .dp_tiny_before, .dp_tiny_after, .dp_risk_tiny, .dp_inexact,
        .host_flags_valid, .host_flags, .host_status
    );

    task automatic report_and_stop();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask

    task automatic clr();
        apb(1'b1, XR, 32'h0000_0000);
    endtask

    task automatic run(input logic [2:0] c, input logic [1:0] s, input logic [31:0] a,
                       input logic [31:0] b, input logic [3:0] f, input logic [3:0] eo,
                       input logic [31:0] er);
        host_u.issue(c, s, a, b, f);
        @(posedge ref_clk);
        check({28'h0, result_valid, bounce, inv_trap, exc_taken}, {28'h0, eo});
        if (eo == RV) begin
            check(result_data, er);
        end
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, dn_mode, ftz_mode, dp_overflow} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(ST, `FPNC_ST_RST);
        rdchk(XR, `FPNC_EX_RST);
        rdchk(8'h10, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        dn_mode <= 1'b1;
        run(FPNC_ARITH, FPNC_COPY, QN, ONE, 4'h0, RV, `FPNC_DNAN_S);
        rdchk(ST, 32'h0000_0000);
        run(FPNC_ARITH, FPNC_COPY, ONE, SN, 4'h0, RV, `FPNC_DNAN_S);
        run(FPNC_ARITH, FPNC_COPY, ONE, TWO, 4'h8, RV, ONE + TWO);
        rdchk(ST, 32'h0000_0011);
        dp_overflow <= 1'b1;
        run(FPNC_ARITH, FPNC_COPY, ONE, ONE, 4'h0, RV, ONE + ONE);
        dp_overflow <= 1'b0;
        rdchk(`FPNC_OFF_INTER, ONE + ONE);
        apb(1'b1, ST, 32'h0000_0100);
        run(FPNC_ARITH, FPNC_COPY, SN, ONE, 4'h0, TR, 32'h0000_0000);
        clr();
        run(FPNC_CMPE, FPNC_COPY, QN, ONE, 4'h0, TR, 32'h0000_0000);
        clr();
        run(FPNC_CMP, FPNC_COPY, SN, ONE, 4'h0, TR, 32'h0000_0000);
        clr();
        apb(1'b1, ST, 32'h0000_0000);
        run(FPNC_CMP, FPNC_COPY, QN, ONE, 4'h0, NO, 32'h0000_0000);
        rdchk(ST, 32'h3000_0000);
        run(FPNC_CMPE, FPNC_COPY, ONE, QN, 4'h0, NO, 32'h0000_0000);
        rdchk(ST, 32'h3000_0001);
        for (int i = 0; i < 3; i++) begin
            run(FPNC_CMP, FPNC_COPY, cmp_a[i], cmp_b[i], 4'h0, NO, 32'h0000_0000);
            run(FPNC_FLAGX, FPNC_COPY, ONE, ONE, 4'h0, NO, 32'h0000_0000);
            @(posedge ref_clk);
            check({28'h0, host_status}, {28'h0, ccode[i]});
        end
        for (int i = 0; i < 2; i++) begin
            dn_mode <= i[0];
            for (int s = 0; s < 3; s++) begin
                run(FPNC_NONAR, s[1:0], NSN, ONE, 4'h0, RV, sgn_r[s]);
            end
            run(FPNC_XFER, FPNC_COPY, NSN, ONE, 4'h0, RV, NSN);
        end
        dn_mode <= 1'b0;
        run(FPNC_ARITH, FPNC_COPY, ONE, QN, 4'h0, BO, 32'h0000_0000);
        rdchk(XR, 32'h8000_0082);
        rdchk(`FPNC_OFF_INSTR, ONE ^ QN);
        check({31'h0, exc_pending}, 32'h0000_0001);
        run(FPNC_ARITH, FPNC_COPY, ONE, TWO, 4'h0, EX, 32'h0000_0000);
        clr();
        run(FPNC_ARITH, FPNC_COPY, ONE, TWO, 4'h0, RV, ONE + TWO);
        run(FPNC_CMPE, FPNC_COPY, SN, ONE, 4'h0, BO, 32'h0000_0000);
        clr();
        run(FPNC_CMP, FPNC_COPY, SUB, ONE, 4'h0, BO, 32'h0000_0000);
        clr();
        apb(1'b1, ST, 32'h0000_0000);
        run(FPNC_ARITH, FPNC_COPY, ONE, TWO, 4'hD, BO, 32'h0000_0000);
        rdchk(ST, 32'h0000_0010);
        rdchk(`FPNC_OFF_INTER, ONE + TWO);
        clr();
        run(FPNC_ARITH, FPNC_COPY, ONE, TWO, 4'h6, BO, 32'h0000_0000);
        rdchk(ST, 32'h0000_0018);
        clr();
        ftz_mode <= 1'b1;
        run(FPNC_ARITH, FPNC_COPY, ONE, TWO, 4'h5, RV, `FPNC_POS_ZERO);
        report_and_stop();
    end
endmodule
